// ==== hdl/cmc_pkg.sv ====
/*
  Constants, register map and state type of the CAN master control block.
  Assumes an 8-bit register port with 4-bit word addresses.
*/
package cmc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFF_MASTER_CONTROL = 4'h0;
  localparam logic [3:0] OFF_MASTER_STATUS = 4'h1;
  localparam logic [3:0] OFF_RX_FIFO = 4'h2;
  localparam logic [3:0] OFF_DIAGNOSTIC = 4'h3;

  // Master control fields and reset value
  localparam logic [7:0] MASTER_CONTROL_RESET = 8'h02;
  localparam logic [7:0] MASTER_CONTROL_MASK = 8'h7f;
  localparam int BIT_AUTO_BUSOFF_RECOVERY = 6;
  localparam int BIT_AUTO_WAKEUP_ENABLE = 5;
  localparam int BIT_NO_AUTO_RETRANSMIT = 4;
  localparam int BIT_RX_FIFO_LOCK_MODE = 3;
  localparam int BIT_TX_ORDER_PRIORITY = 2;
  localparam int BIT_SLEEP_REQUEST = 1;
  localparam int BIT_INIT_REQUEST = 0;

  // Master status fields
  localparam int BIT_INIT_ACKNOWLEDGE = 0;
  localparam int BIT_DOZE_ACKNOWLEDGE = 1;
  localparam int BIT_BUS_OFF = 2;
  localparam int BIT_RECEIVING_FLAG = 5;

  // Receive FIFO register fields
  localparam int BIT_PENDING_LO = 0;
  localparam int BIT_OVERRUN = 4;
  localparam int BIT_FIFO_OUTPUT_RELEASE = 5;

  // Diagnostic register fields
  localparam int BIT_BUSOFF_SW_RECOVER = 0;
  localparam int BIT_RX_PIN = 3;

  // Bus timing, in CAN bit times, CPU cycles or 11-bit recessive runs, and receive FIFO depth in entries
  localparam int BIT_CYCLES = 8;
  localparam int SAMPLE_OFFSET = 4;
  localparam int RECESSIVE_RUN_BITS = 11;
  localparam int BUSOFF_RUN_COUNT = 128;
  localparam int ACK_TO_STORE_BITS = 6;
  localparam int ACK_TO_END_BITS = 8;
  localparam int FIFO_DEPTH = 3;

  typedef enum logic [2:0] {
    ST_INIT, ST_SYNC, ST_NORMAL, ST_SLEEP, ST_BUSOFF
  } cmc_state_t;
endpackage : cmc_pkg

// ==== hdl/cmc_master_ctrl.sv ====
/*
  CAN master control: mode register, init/sleep/bus-off sequencing, receive
  status timing after the acknowledge bit and receive FIFO slot bookkeeping.
  Assumes the protocol engine on the same clock reports the acknowledge bit,
  frame errors, bus-off entry, transmit activity and transmit failures.
*/
// Contract
// - Control register 8 bits, reset 02h, mode bits
// - Auto recovery after 128 runs of 11 recessive
// - Without auto recovery, wait for software request
// - Receiving flag clears 8 bits after acknowledge
// - In frame, at most 5 recessive bits
// - Bit time is eight CPU cycles
// - Init entry after activity, exit after 11 recessive
// - Sleep after frame; start of frame wakes
// - No-retransmit sends once, else retry failures
// - FIFO store late in frame, release safe
`timescale 1ns/1ps
`default_nettype none
module cmc_master_ctrl #(
  parameter int BIT_CYCLES = cmc_pkg::BIT_CYCLES,
  parameter int SAMPLE_OFFSET = cmc_pkg::SAMPLE_OFFSET
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR_STB,
  input wire logic I_RD_STB,
  output logic [7:0] O_RDATA,
  input wire logic I_CAN_RX,
  input wire logic I_ACK_DOMINANT,
  input wire logic I_RX_ERROR,
  input wire logic I_TX_BUSY,
  input wire logic I_TX_FAIL,
  input wire logic I_BUS_OFF_ENTER,
  output logic O_INIT_ACK,
  output logic O_DOZE_ACK,
  output logic O_BUS_OFF,
  output logic O_RECEIVING,
  output logic O_RX_STORE,
  output logic [1:0] O_STORE_SLOT,
  output logic [1:0] O_READ_SLOT,
  output logic [1:0] O_PENDING,
  output logic O_TX_RETRY,
  output logic O_NO_RETRANSMIT,
  output logic O_TX_ORDER_PRIORITY,
  output logic O_RX_FIFO_LOCK
);
  localparam int STORE_CYC = cmc_pkg::ACK_TO_STORE_BITS * BIT_CYCLES + SAMPLE_OFFSET;
  localparam int END_CYC = cmc_pkg::ACK_TO_END_BITS * BIT_CYCLES;

  function automatic logic [1:0] slot_add(input logic [1:0] a, input logic [1:0] b);
    logic [2:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 3'(cmc_pkg::FIFO_DEPTH)) begin
      s = s - 3'(cmc_pkg::FIFO_DEPTH);
    end
    return s[1:0];
  endfunction : slot_add

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
    return addr == off;
  endfunction : hit

  // Reset release
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Receive pin synchroniser and filter
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_filt_reg, rx_filt_next;
  always_comb begin
    rx_filt_next = (rx_s2_reg == rx_s3_reg) ? rx_s2_reg : rx_filt_reg;
  end
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
      rx_filt_reg <= 1'b1;
    end else begin
      rx_s1_reg <= I_CAN_RX;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      rx_filt_reg <= rx_filt_next;
    end
  end

  // Control state
  cmc_pkg::cmc_state_t state_reg, state_next;
  logic [7:0] mcr_reg, mcr_next;
  logic rx_prev_reg, rx_prev_next;
  logic [5:0] bit_cnt_reg, bit_cnt_next;
  logic [3:0] run_reg, run_next;
  logic [7:0] busoff_cnt_reg, busoff_cnt_next;
  logic sw_recover_reg, sw_recover_next;
  logic receiving_reg, receiving_next;
  logic eof_active_reg, eof_active_next;
  logic [9:0] eof_cnt_reg, eof_cnt_next;
  logic [1:0] rd_slot_reg, rd_slot_next;
  logic [1:0] count_reg, count_next;
  logic [1:0] store_slot_reg, store_slot_next;
  logic store_reg, store_next;
  logic overrun_reg, overrun_next;
  logic retry_reg, retry_next;
  logic [7:0] rdata_reg, rdata_next;

  logic wr_mcr, wr_fifo, wr_diag, rx_fall, sample, idle11, sof, active, store, release_req;
  logic armed;

  always_comb begin
    wr_mcr = I_WR_STB && hit(I_ADDR, cmc_pkg::OFF_MASTER_CONTROL);
    wr_fifo = I_WR_STB && hit(I_ADDR, cmc_pkg::OFF_RX_FIFO);
    wr_diag = I_WR_STB && hit(I_ADDR, cmc_pkg::OFF_DIAGNOSTIC);
    rx_prev_next = rx_filt_reg;
    rx_fall = rx_prev_reg && !rx_filt_reg;
    if (rx_fall || bit_cnt_reg == 6'(BIT_CYCLES - 1)) begin
      bit_cnt_next = '0;
    end else begin
      bit_cnt_next = bit_cnt_reg + 6'h01;
    end
    sample = bit_cnt_reg == 6'(SAMPLE_OFFSET);
    idle11 = sample && rx_filt_reg && run_reg == 4'(cmc_pkg::RECESSIVE_RUN_BITS - 1);
    run_next = run_reg;
    if (sample) begin
      run_next = (!rx_filt_reg || idle11) ? 4'h0 : run_reg + 4'h1;
    end
    sof = sample && !rx_filt_reg;
    active = receiving_reg || I_TX_BUSY;

    mcr_next = mcr_reg;
    if (wr_mcr) begin
      mcr_next = I_WDATA & cmc_pkg::MASTER_CONTROL_MASK;
    end
    sw_recover_next = sw_recover_reg;
    if (wr_diag && I_WDATA[cmc_pkg::BIT_BUSOFF_SW_RECOVER]) begin
      sw_recover_next = 1'b1;
    end

    state_next = state_reg;
    busoff_cnt_next = busoff_cnt_reg;
    armed = mcr_reg[cmc_pkg::BIT_AUTO_BUSOFF_RECOVERY] || sw_recover_reg;
    if (state_reg == cmc_pkg::ST_INIT ||
        (state_reg == cmc_pkg::ST_NORMAL && I_BUS_OFF_ENTER) ||
        (state_reg == cmc_pkg::ST_BUSOFF && !armed && wr_diag &&
         I_WDATA[cmc_pkg::BIT_BUSOFF_SW_RECOVER])) begin
      run_next = 4'h0;
    end
    case (state_reg)
      cmc_pkg::ST_INIT: begin
        if (!mcr_reg[cmc_pkg::BIT_INIT_REQUEST]) begin
          state_next = cmc_pkg::ST_SYNC;
        end
      end
      cmc_pkg::ST_SYNC: begin
        if (mcr_reg[cmc_pkg::BIT_INIT_REQUEST]) begin
          state_next = cmc_pkg::ST_INIT;
        end else if (idle11) begin
          state_next = cmc_pkg::ST_NORMAL;
        end
      end
      cmc_pkg::ST_NORMAL: begin
        if (I_BUS_OFF_ENTER) begin
          state_next = cmc_pkg::ST_BUSOFF;
          busoff_cnt_next = '0;
        end else if (mcr_reg[cmc_pkg::BIT_INIT_REQUEST] && !active) begin
          state_next = cmc_pkg::ST_INIT;
        end else if (mcr_reg[cmc_pkg::BIT_SLEEP_REQUEST] && !active) begin
          state_next = cmc_pkg::ST_SLEEP;
        end
      end
      cmc_pkg::ST_SLEEP: begin
        if (mcr_reg[cmc_pkg::BIT_INIT_REQUEST]) begin
          state_next = cmc_pkg::ST_INIT;
        end else if (!mcr_reg[cmc_pkg::BIT_SLEEP_REQUEST]) begin
          state_next = cmc_pkg::ST_NORMAL;
        end else if (mcr_reg[cmc_pkg::BIT_AUTO_WAKEUP_ENABLE] && sof) begin
          state_next = cmc_pkg::ST_NORMAL;
          if (!wr_mcr) begin
            mcr_next[cmc_pkg::BIT_SLEEP_REQUEST] = 1'b0;
          end
        end
      end
      cmc_pkg::ST_BUSOFF: begin
        if (armed && idle11) begin
          if (busoff_cnt_reg == 8'(cmc_pkg::BUSOFF_RUN_COUNT - 1)) begin
            state_next = cmc_pkg::ST_NORMAL;
            busoff_cnt_next = '0;
            sw_recover_next = 1'b0;
          end else begin
            busoff_cnt_next = busoff_cnt_reg + 8'h01;
          end
        end
      end
      default: state_next = cmc_pkg::ST_INIT;
    endcase

    receiving_next = receiving_reg;
    eof_active_next = eof_active_reg;
    eof_cnt_next = eof_cnt_reg;
    store = 1'b0;
    if (state_reg == cmc_pkg::ST_NORMAL && !receiving_reg && sof) begin
      receiving_next = 1'b1;
    end
    if (I_RX_ERROR || state_reg == cmc_pkg::ST_BUSOFF) begin
      receiving_next = 1'b0;
      eof_active_next = 1'b0;
    end else if (eof_active_reg) begin
      eof_cnt_next = eof_cnt_reg + 10'h001;
      store = eof_cnt_reg == 10'(STORE_CYC - 1);
      if (eof_cnt_reg == 10'(END_CYC - 1)) begin
        receiving_next = 1'b0;
        eof_active_next = 1'b0;
      end
    end else if (receiving_reg && I_ACK_DOMINANT) begin
      eof_active_next = 1'b1;
      eof_cnt_next = '0;
    end

    release_req = wr_fifo && I_WDATA[cmc_pkg::BIT_FIFO_OUTPUT_RELEASE] && count_reg != 2'h0;
    rd_slot_next = release_req ? slot_add(rd_slot_reg, 2'h1) : rd_slot_reg;
    count_next = count_reg;
    store_next = 1'b0;
    store_slot_next = store_slot_reg;
    overrun_next = overrun_reg;
    if (wr_fifo && I_WDATA[cmc_pkg::BIT_OVERRUN]) begin
      overrun_next = 1'b0;
    end
    if (store && (release_req || count_reg != 2'(cmc_pkg::FIFO_DEPTH))) begin
      store_next = 1'b1;
      store_slot_next = slot_add(rd_slot_reg, count_reg);
      count_next = release_req ? count_reg : count_reg + 2'h1;
    end else if (store) begin
      overrun_next = 1'b1;
      if (!mcr_reg[cmc_pkg::BIT_RX_FIFO_LOCK_MODE]) begin
        store_next = 1'b1;
        store_slot_next = slot_add(rd_slot_reg, 2'h2);
      end
    end else if (release_req) begin
      count_next = count_reg - 2'h1;
    end

    retry_next = I_TX_FAIL && !mcr_reg[cmc_pkg::BIT_NO_AUTO_RETRANSMIT];

    rdata_next = 8'h00;
    if (I_RD_STB) begin
      case (I_ADDR)
        cmc_pkg::OFF_MASTER_CONTROL: rdata_next = mcr_reg;
        cmc_pkg::OFF_MASTER_STATUS: begin
          rdata_next[cmc_pkg::BIT_INIT_ACKNOWLEDGE] = O_INIT_ACK;
          rdata_next[cmc_pkg::BIT_DOZE_ACKNOWLEDGE] = state_reg == cmc_pkg::ST_SLEEP;
          rdata_next[cmc_pkg::BIT_BUS_OFF] = state_reg == cmc_pkg::ST_BUSOFF;
          rdata_next[cmc_pkg::BIT_RECEIVING_FLAG] = receiving_reg;
        end
        cmc_pkg::OFF_RX_FIFO: begin
          rdata_next[cmc_pkg::BIT_PENDING_LO +: 2] = count_reg;
          rdata_next[cmc_pkg::BIT_OVERRUN] = overrun_reg;
        end
        cmc_pkg::OFF_DIAGNOSTIC: begin
          rdata_next[cmc_pkg::BIT_BUSOFF_SW_RECOVER] = sw_recover_reg;
          rdata_next[cmc_pkg::BIT_RX_PIN] = rx_filt_reg;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cmc_pkg::ST_SLEEP;
      mcr_reg <= cmc_pkg::MASTER_CONTROL_RESET;
      rx_prev_reg <= 1'b1;
      bit_cnt_reg <= '0;
      run_reg <= '0;
      busoff_cnt_reg <= '0;
      sw_recover_reg <= 1'b0;
      receiving_reg <= 1'b0;
      eof_active_reg <= 1'b0;
      eof_cnt_reg <= '0;
      rd_slot_reg <= '0;
      count_reg <= '0;
      store_slot_reg <= '0;
      store_reg <= 1'b0;
      overrun_reg <= 1'b0;
      retry_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      mcr_reg <= mcr_next;
      rx_prev_reg <= rx_prev_next;
      bit_cnt_reg <= bit_cnt_next;
      run_reg <= run_next;
      busoff_cnt_reg <= busoff_cnt_next;
      sw_recover_reg <= sw_recover_next;
      receiving_reg <= receiving_next;
      eof_active_reg <= eof_active_next;
      eof_cnt_reg <= eof_cnt_next;
      rd_slot_reg <= rd_slot_next;
      count_reg <= count_next;
      store_slot_reg <= store_slot_next;
      store_reg <= store_next;
      overrun_reg <= overrun_next;
      retry_reg <= retry_next;
      rdata_reg <= rdata_next;
    end
  end

  assign O_RDATA = rdata_reg;
  // Acknowledge stands until the bus is synchronised again
  assign O_INIT_ACK = state_reg == cmc_pkg::ST_INIT || state_reg == cmc_pkg::ST_SYNC;
  assign O_DOZE_ACK = state_reg == cmc_pkg::ST_SLEEP;
  assign O_BUS_OFF = state_reg == cmc_pkg::ST_BUSOFF;
  assign O_RECEIVING = receiving_reg;
  assign O_RX_STORE = store_reg;
  assign O_STORE_SLOT = store_slot_reg;
  assign O_READ_SLOT = rd_slot_reg;
  assign O_PENDING = count_reg;
  assign O_TX_RETRY = retry_reg;
  assign O_NO_RETRANSMIT = mcr_reg[cmc_pkg::BIT_NO_AUTO_RETRANSMIT];
  assign O_TX_ORDER_PRIORITY = mcr_reg[cmc_pkg::BIT_TX_ORDER_PRIORITY];
  assign O_RX_FIFO_LOCK = mcr_reg[cmc_pkg::BIT_RX_FIFO_LOCK_MODE];

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!rst_n);

  property p_mode_write;
    wr_mcr && state_reg != cmc_pkg::ST_SLEEP |=> mcr_reg == ($past(I_WDATA) & 8'h7f);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");
  property p_top_zero;
    I_RD_STB && I_ADDR == cmc_pkg::OFF_MASTER_CONTROL |=> !O_RDATA[7];
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("bit 7 reads one");
  property p_auto_exit;
    O_BUS_OFF && armed && idle11 && busoff_cnt_reg == 8'h7f |=> state_reg == cmc_pkg::ST_NORMAL;
  endproperty
  a_auto_exit: assert property (p_auto_exit) else $error("bus-off not left");
  property p_hold_busoff;
    O_BUS_OFF && !armed |=> O_BUS_OFF;
  endproperty
  a_hold_busoff: assert property (p_hold_busoff) else $error("bus-off left alone");
  property p_rx_end;
    $fell(receiving_reg) && !$past(I_RX_ERROR) && !$past(O_BUS_OFF) |->
      $past(eof_cnt_reg) == 10'(END_CYC - 1);
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("receiving ended early");
  property p_bit_time;
    (sample && !rx_fall) ##1 (!rx_fall [*7]) |=> sample;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("bit time wrong");
  property p_sync_exit;
    state_reg == cmc_pkg::ST_SYNC && !mcr_reg[0] && idle11 |=> !O_INIT_ACK && !O_BUS_OFF;
  endproperty
  a_sync_exit: assert property (p_sync_exit) else $error("sync exit wrong");
  property p_sleep_wait;
    state_reg == cmc_pkg::ST_NORMAL && active |=> !O_DOZE_ACK;
  endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("slept mid frame");
  property p_retry;
    I_TX_FAIL |=> O_TX_RETRY == !$past(O_NO_RETRANSMIT);
  endproperty
  a_retry: assert property (p_retry) else $error("retry wrong");
  property p_release_store;
    store && release_req |=> O_PENDING == $past(O_PENDING) && O_RX_STORE &&
      O_READ_SLOT == slot_add($past(O_READ_SLOT), 2'h1);
  endproperty
  a_release_store: assert property (p_release_store) else $error("fifo pointer lost");
endmodule : cmc_master_ctrl
`default_nettype wire

// ==== test/cmc_can_node.sv ====
/*
  Behavioural CAN node and protocol-engine stand-in: sends stuffed frames on
  the receive pin and pulses the acknowledge flag. Assumes the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cmc_can_node (
  input wire logic i_clk,
  output logic o_can_rx,
  output logic o_ack_dominant
);
  initial begin
    o_can_rx = 1'b1;
    o_ack_dominant = 1'b0;
  end
  task automatic drive_bit(input logic b, input logic ack);
    for (int c = 0; c < cmc_pkg::BIT_CYCLES; c++) begin
      @(posedge i_clk);
      o_can_rx <= b;
      o_ack_dominant <= ack && (c == cmc_pkg::SAMPLE_OFFSET);
    end
  endtask : drive_bit
  // Start bit, stuffed payload, optional acknowledge, recessive tail
  task automatic send_frame(input logic [15:0] data, input int len, input logic with_ack);
    logic last;
    int run;
    drive_bit(1'b0, 1'b0);
    last = 1'b0;
    run = 1;
    for (int i = 0; i < len; i++) begin
      if (run == 5) begin
        drive_bit(!last, 1'b0);
        last = !last;
        run = 1;
      end
      run = (data[i] == last) ? run + 1 : 1;
      last = data[i];
      drive_bit(data[i], 1'b0);
    end
    if (run == 5) drive_bit(!last, 1'b0);
    if (with_ack) drive_bit(1'b0, 1'b1);
    // Idle bus rests recessive
    repeat (11) drive_bit(1'b1, 1'b0);
  endtask : send_frame
endmodule : cmc_can_node
`default_nettype wire

// ==== test/cmc_master_ctrl_tb_top.sv ====
/*
  Self-checking bench for the CAN master control block.
  Assumes the design and package under hdl/ and the node model under test/.
*/
`timescale 1ns/1ps
`default_nettype none
module cmc_master_ctrl_tb_top;
  logic clk, rst_b, wr_stb, rd_stb, ack_dom, rx_error, tx_busy, tx_fail, boff_in, can_rx;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic init_ack, doze_ack, bus_off, receiving, rx_store, no_retx, tx_order, fifo_lock, tx_retry;
  logic [1:0] store_slot, read_slot, pending;
  logic [31:0] r;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'h07efdf53;
  int cyc = 0;
  int ack_cyc = 0;
  logic rd_pend = 1'b0;
  logic recv_prev = 1'b0;
  logic [7:0] rd_q[$];
  logic [1:0] slot_q[$];
  // Cycles from the edge that takes the acknowledge to the edge that sees the output
  localparam int STORE_SEEN = cmc_pkg::ACK_TO_STORE_BITS * cmc_pkg::BIT_CYCLES +
    cmc_pkg::SAMPLE_OFFSET + 1;
  localparam int END_SEEN = cmc_pkg::ACK_TO_END_BITS * cmc_pkg::BIT_CYCLES + 1;

  cmc_master_ctrl dut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR_STB(wr_stb), .I_RD_STB(rd_stb), .O_RDATA(rdata), .I_CAN_RX(can_rx),
    .I_ACK_DOMINANT(ack_dom), .I_RX_ERROR(rx_error), .I_TX_BUSY(tx_busy),
    .I_TX_FAIL(tx_fail), .I_BUS_OFF_ENTER(boff_in), .O_INIT_ACK(init_ack),
    .O_DOZE_ACK(doze_ack), .O_BUS_OFF(bus_off), .O_RECEIVING(receiving),
    .O_RX_STORE(rx_store), .O_STORE_SLOT(store_slot), .O_READ_SLOT(read_slot),
    .O_PENDING(pending), .O_TX_RETRY(tx_retry), .O_NO_RETRANSMIT(no_retx),
    .O_TX_ORDER_PRIORITY(tx_order), .O_RX_FIFO_LOCK(fifo_lock));
  cmc_can_node node (.i_clk(clk), .o_can_rx(can_rx), .o_ack_dominant(ack_dom));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic compare(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : compare

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask : reg_rd

  task automatic pulse_fail_or_boff(input logic boff);
    @(posedge clk);
    if (boff) boff_in <= 1'b1;
    else tx_fail <= 1'b1;
    @(posedge clk);
    boff_in <= 1'b0;
    tx_fail <= 1'b0;
    @(posedge clk);
  endtask : pulse_fail_or_boff

  task automatic busoff_exit;
    int n;
    n = 0;
    while (bus_off === 1'b1 && n < 13000) begin
      @(posedge clk);
      n++;
    end
    compare("busoff_exit_window", 16'h1, 16'(n >= 11256 && n <= 11330));
  endtask : busoff_exit

  always @(posedge clk) begin
    if (rd_pend) compare("rdata", {8'h00, rd_q.pop_front()}, {8'h00, rdata});
    rd_pend = rd_stb;
    if (ack_dom) ack_cyc = cyc;
    if (rx_store) begin
      compare("store_slot", {14'h0, slot_q.pop_front()}, {14'h0, store_slot});
      compare("store_delay", 16'(STORE_SEEN), 16'(cyc - ack_cyc));
    end
    if (recv_prev && !receiving) compare("receiving_end", 16'(END_SEEN), 16'(cyc - ack_cyc));
    recv_prev = receiving;
    cyc++;
  end

  initial begin
    #(40 * 80000);
    num_errors++;
    summarize();
  end

  initial begin
    {rst_b, wr_stb, rd_stb, rx_error, tx_busy, tx_fail, boff_in} = 7'h00;
    addr = 4'h0;
    wdata = 8'h00;
    cycles(20);
    rst_b <= 1'b1;
    cycles(3);
    reg_rd(4'h0, 8'h02);
    reg_rd(4'h1, 8'h02);
    reg_rd(4'h7, 8'h00);
    reg_wr(4'h0, 8'h7f);
    reg_rd(4'h0, 8'h7f);
    compare("mode_bits", 16'h7, {13'h0, no_retx, tx_order, fifo_lock});
    compare("init_ack_set", 16'h1, {15'h0, init_ack});
    reg_wr(4'h0, 8'h00);
    cycles(70);
    compare("init_ack_sync", 16'h1, {15'h0, init_ack});
    cycles(40);
    compare("init_ack_clear", 16'h0, {15'h0, init_ack});
    for (int nr = 0; nr < 2; nr++) begin
      reg_wr(4'h0, 8'(nr << 4));
      pulse_fail_or_boff(1'b0);
      compare("tx_retry", 16'(nr == 0), {15'h0, tx_retry});
    end
    tx_busy <= 1'b1;
    reg_wr(4'h0, 8'h01);
    cycles(20);
    compare("init_wait_busy", 16'h0, {15'h0, init_ack});
    tx_busy <= 1'b0;
    cycles(3);
    compare("init_after_busy", 16'h1, {15'h0, init_ack});
    reg_wr(4'h0, 8'h00);
    cycles(120);
    reg_wr(4'h0, 8'h22);
    cycles(3);
    compare("doze_set", 16'h1, {15'h0, doze_ack});
    node.send_frame(16'h0000, 0, 1'b0);
    reg_rd(4'h0, 8'h20);
    compare("doze_wake", 16'h0, {15'h0, doze_ack});
    cycles(20);
    for (int f = 0; f < 3; f++) begin
      slot_q.push_back(2'(f));
      r = $random(seed);
      if (f < 2) begin
        node.send_frame(r[15:0], 16, 1'b1);
        compare("pending", 16'(f + 1), {14'h0, pending});
      end else begin
        fork
          node.send_frame(r[15:0], 16, 1'b1);
          begin
            @(posedge ack_dom);
            // Release lands in the cycle of the store
            cycles(STORE_SEEN - 2);
            reg_wr(4'h2, 8'h20);
          end
        join
      end
    end
    compare("pending_race", 16'h2, {14'h0, pending});
    compare("read_slot_race", 16'h1, {14'h0, read_slot});
    reg_rd(4'h2, 8'h02);
    reg_wr(4'h2, 8'h20);
    reg_wr(4'h2, 8'h20);
    cycles(2);
    compare("read_slot_wrap", 16'h0, {12'h0, read_slot, pending});
    reg_wr(4'h0, 8'h40);
    pulse_fail_or_boff(1'b1);
    compare("bus_off_auto", 16'h1, {15'h0, bus_off});
    busoff_exit();
    reg_wr(4'h0, 8'h00);
    pulse_fail_or_boff(1'b1);
    cycles(12000);
    compare("bus_off_held", 16'h1, {15'h0, bus_off});
    reg_wr(4'h3, 8'h01);
    busoff_exit();
    compare("queues_empty", 16'h0, 16'(rd_q.size() + slot_q.size()));
    summarize();
  end
endmodule : cmc_master_ctrl_tb_top
`default_nettype wire
